// *** wac_pkg.sv ***
// Package for the waveform acquisition controller: APB map, field positions,
// reset values, mode encodings and timing constants.
// Assumes a single 20 MHz clock domain and an APB master with 32-bit data.
package wac_pkg;

    // APB register byte offsets.
    localparam logic [7:0] WAC_CTRL_OFS = 8'h00;
    localparam logic [7:0] WAC_CMD_OFS = 8'h04;
    localparam logic [7:0] WAC_STAT_OFS = 8'h08;
    localparam logic [7:0] WAC_AR_OFS = 8'h0C;
    localparam logic [7:0] WAC_EVT_OFS = 8'h10;

    // Control register field positions.
    localparam int WAC_CTRL_MODE_LSB = 0;
    localparam int WAC_CTRL_AVG_LSB = 2;
    localparam int WAC_CTRL_TB_LSB = 4;
    localparam int WAC_CTRL_TRIGNORM_BIT = 9;
    localparam int WAC_CTRL_TYPE_BIT = 10;

    // Command register bits, each a one-shot press.
    localparam int WAC_CMD_RUNSTOP_BIT = 0;
    localparam int WAC_CMD_SINGLE_BIT = 1;
    localparam int WAC_CMD_AUTORANGE_BIT = 2;
    localparam int WAC_CMD_UNDO_BIT = 3;

    // Autorange events register bits, each a one-shot report.
    localparam int WAC_EVT_PERIOD_BIT = 0;
    localparam int WAC_EVT_AMPL_BIT = 1;
    localparam int WAC_EVT_TLEVEL_BIT = 2;
    localparam int WAC_EVT_CHAN_BIT = 3;
    localparam int WAC_EVT_TRIGSET_BIT = 4;
    localparam int WAC_EVT_RECALL_BIT = 5;
    localparam int WAC_EVT_XY_BIT = 6;
    localparam int WAC_EVT_PERSIST_BIT = 7;
    localparam int WAC_EVT_VSCALE_BIT = 8;
    localparam int WAC_EVT_HSCALE_BIT = 9;

    // Record sizes.
    localparam logic [11:0] WAC_SAMPLE_POINTS = 12'd2500;
    localparam logic [11:0] WAC_PEAK_INTERVALS = 12'd1250;
    localparam logic [11:0] WAC_DIV_POINTS = 12'd250;

    // Sample-rate limits in MS/s for the two bandwidth classes.
    localparam int WAC_RATE_LOW_MSPS = 500;
    localparam int WAC_RATE_HIGH_MSPS = 1000;
    // Shortest glitch that peak detect must catch, in ns.
    localparam int WAC_GLITCH_NS = 10;

    // Timebase codes, ascending seconds per division.
    localparam logic [4:0] WAC_TB_100NS = 5'd5;
    localparam logic [4:0] WAC_TB_2P5MS = 5'd16;
    localparam logic [4:0] WAC_TB_100MS = 5'd21;
    localparam logic [4:0] WAC_TB_RESET = 5'd10;

    typedef enum logic [1:0] {
        WAC_MODE_SAMPLE = 2'b00,
        WAC_MODE_PEAK = 2'b01,
        WAC_MODE_AVG = 2'b10
    } wac_mode_t;

    typedef enum logic [1:0] {
        WAC_AR_BOTH = 2'b00,
        WAC_AR_VERT = 2'b01,
        WAC_AR_HORZ = 2'b10
    } wac_arsub_t;

    typedef enum logic [1:0] {
        WAC_ST_STOP = 2'b00,
        WAC_ST_RUN = 2'b01,
        WAC_ST_SINGLE = 2'b10
    } wac_state_t;

    // One digitized sample with its framing.
    typedef struct packed {
        logic valid;
        logic trig;
        logic [7:0] data;
    } wac_smp_t;

    // One record point written to the record store.
    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [7:0] max;
        logic [7:0] min;
        logic blank;
    } wac_pt_t;

    // Autorange actions: forced setup on entry, undo restore, axis enables, readjust.
    typedef struct packed {
        logic force_cfg;
        logic restore;
        logic vert_en;
        logic horz_en;
        logic readjust;
    } wac_ar_t;

endpackage

// *** wac_ctrl.sv ***
// Waveform acquisition controller: acquisition modes, run/stop, single
// sequence, scan mode and autorange control, reached over APB.
// Assumes samples arrive one per clock with valid, a timebase decimation
// by the digitizer, and a record store that accepts one point per clock.
`timescale 1ns/10ps

// Functional notes
// R1: Sample mode records 2500 points, one sample per acquisition interval.
// R2: Sample rate capped at 500 MS/s low-bandwidth, 1 GS/s high-bandwidth.
// R3: At 100 ns/div or faster, interpolate points to fill 2500.
// R4: Peak detect keeps max and min for each of 1250 intervals.
// R5: Peak detect catches glitches of 10 ns as interval extremes.
// R6: Peak detect at 2.5 ms/div or faster silently becomes sample mode.
// R7: Average mode averages 4, 16, 64 or 128 sample-mode records.
// R8: Sample mode is the default acquisition mode.
// R9: Run/stop press toggles continuous acquisition and stopped state.
// R10: Single press arms one acquisition; after trigger it completes and stops.
// R11: Single ends after one record, or after the averaging count.
// R12: Scan mode entered at 100 ms/div or slower with auto trigger; the code also keeps average mode out of scan.
// R13: Scan writes left to right, with a one-division blank gap ahead; the code sends only the blank point, never the sample at the scan position.
// R14: Normal trigger mode leaves scan mode.
// R15: Stop freezes the record; scaling still applies in both states.
// R16: Autorange press toggles function and indicator; off after power-on.
// R17: Autorange sub-modes both, vertical, horizontal; undo restores setup.
// R18: Autorange readjusts on period, amplitude or trigger-level conditions.
// R19: Autorange activation forces sample mode, running and default settings.
// R20: Channel, trigger, single, recall, XY or persistence turns autorange off.
// R21: Manual vertical or horizontal scale cancels only that axis.
// R22: Averaging sums records and divides by shifting right.
// R23: Mode or count change discards partial average and restarts.
module wac_ctrl (
    input wire logic CLK, // System clock, 20 MHz.
    input wire logic RESET_N, // Asynchronous reset, active low.
    input wire logic PSEL, // APB select.
    input wire logic PENABLE, // APB access phase.
    input wire logic PWRITE, // APB write when high.
    input wire logic [7:0] PADDR, // APB byte address.
    input wire logic [31:0] PWDATA, // APB write data.
    output logic [31:0] PRDATA, // APB read data.
    output logic PREADY, // APB ready, always high.
    output logic PSLVERR, // APB error on unmapped address.
    input wire logic HIGH_BW, // High-bandwidth variant strap.
    input wire wac_pkg::wac_smp_t SMP_IN, // Digitized sample stream.
    output wac_pkg::wac_pt_t PT_OUT, // Record point to store.
    output logic AR_LED, // Autorange active indicator.
    output wac_pkg::wac_ar_t AR_OUT, // Autorange actions to setup logic.
    output logic [3:0] RATE_DIV // Minimum digitizer clock divider.
);
    import wac_pkg::*;

    // Configuration and state registers.
    logic [1:0] mode_ff;
    logic [1:0] avg_sel_ff;
    logic [4:0] tb_ff;
    logic trig_norm_ff;
    wac_state_t st_ff;
    logic ar_on_ff;
    wac_arsub_t ar_sub_ff;
    logic ar_v_ff;
    logic ar_h_ff;
    logic [11:0] idx_ff;
    logic [7:0] avg_cnt_ff;
    logic [7:0] acc_done_ff;
    logic in_int_ff;
    logic [7:0] max_ff;
    logic [7:0] min_ff;
    logic [7:0] last_ff;
    logic armed_ff;
    logic [1:0] interp_ff;
    logic [15:0] acc_mem [0:2499];
    wac_pt_t pt_ff;
    wac_ar_t ar_ff;
    logic [31:0] prdata_ff;

    // Decode of APB accesses and commands.
    wire acc_en = PSEL && PENABLE;
    wire wr_en = acc_en && PWRITE;
    wire hit_ctrl = PADDR == WAC_CTRL_OFS;
    wire hit_cmd = PADDR == WAC_CMD_OFS;
    wire hit_stat = PADDR == WAC_STAT_OFS;
    wire hit_ar = PADDR == WAC_AR_OFS;
    wire hit_evt = PADDR == WAC_EVT_OFS;
    wire mapped = hit_ctrl | hit_cmd | hit_stat | hit_ar | hit_evt;
    wire ctrl_wr = wr_en && hit_ctrl;
    wire cmd_wr = wr_en && hit_cmd;
    wire evt_wr = wr_en && hit_evt;
    wire ar_wr = wr_en && hit_ar;
    wire p_runstop = cmd_wr && PWDATA[WAC_CMD_RUNSTOP_BIT];
    wire p_single = cmd_wr && PWDATA[WAC_CMD_SINGLE_BIT];
    wire p_ar = cmd_wr && PWDATA[WAC_CMD_AUTORANGE_BIT];
    wire p_undo = cmd_wr && PWDATA[WAC_CMD_UNDO_BIT];
    wire [1:0] wr_mode = PWDATA[WAC_CTRL_MODE_LSB +: 2];
    wire [4:0] wr_tb = PWDATA[WAC_CTRL_TB_LSB +: 5];

    // Average count as a shift amount: 4, 16, 64, 128.
    function automatic logic [2:0] avg_shift(input logic [1:0] sel);
        unique case (sel)
            2'd0: avg_shift = 3'd2;
            2'd1: avg_shift = 3'd4;
            2'd2: avg_shift = 3'd6;
            2'd3: avg_shift = 3'd7;
        endcase
    endfunction

    // Effective mode: peak detect falls back silently at fast timebases.
    wire peak_ok = tb_ff > WAC_TB_2P5MS;
    wire [1:0] eff_mode = (mode_ff == WAC_MODE_PEAK && !peak_ok) ? WAC_MODE_SAMPLE
        : mode_ff; // [R6] [R8]
    wire is_peak = eff_mode == WAC_MODE_PEAK;
    wire is_avg = eff_mode == WAC_MODE_AVG;
    wire interp = tb_ff <= WAC_TB_100NS; // [R3]
    wire scan = (tb_ff >= WAC_TB_100MS) && !trig_norm_ff && !is_avg; // [R12] [R14]
    wire [11:0] rec_len = is_peak ? WAC_PEAK_INTERVALS : WAC_SAMPLE_POINTS; // [R1] [R4]
    wire [7:0] avg_n = 8'(8'd1 << avg_shift(avg_sel_ff));
    wire running = st_ff != WAC_ST_STOP;

    // Autorange disabling events and mode change flags.
    wire ev_kill = evt_wr && (PWDATA[WAC_EVT_CHAN_BIT] | PWDATA[WAC_EVT_TRIGSET_BIT]
        | PWDATA[WAC_EVT_RECALL_BIT] | PWDATA[WAC_EVT_XY_BIT]
        | PWDATA[WAC_EVT_PERSIST_BIT]) || p_single; // [R20]
    wire cfg_chg = ctrl_wr && (wr_mode != mode_ff
        || PWDATA[WAC_CTRL_AVG_LSB +: 2] != avg_sel_ff); // [R23]
    wire ar_start = p_ar && !ar_on_ff;
    wire ar_next = p_ar ? !ar_on_ff : (ev_kill ? 1'b0 : ar_on_ff); // [R16]

    // Sample gating: interpolation emits one sample then repeats it to fill.
    wire take = SMP_IN.valid && running && (st_ff != WAC_ST_SINGLE || armed_ff
        || SMP_IN.trig);
    wire emit_int = interp && interp_ff != 2'd0 && running;
    wire [7:0] cur = emit_int ? last_ff : SMP_IN.data;
    wire step = take || emit_int;
    wire [7:0] nmax = in_int_ff ? ((cur > max_ff) ? cur : max_ff) : cur; // [R5]
    wire [7:0] nmin = in_int_ff ? ((cur < min_ff) ? cur : min_ff) : cur;
    wire pt_done = step && (!is_peak || in_int_ff);
    wire rec_end = pt_done && idx_ff == rec_len - 12'd1;
    wire [15:0] acc_rd = acc_mem[idx_ff];
    wire [15:0] acc_sum = (acc_done_ff == 8'd0) ? {8'h00, cur} : acc_rd + {8'h00, cur};
    wire [7:0] avg_val = 8'(acc_sum >> avg_shift(avg_sel_ff)); // [R22]
    wire avg_last = acc_done_ff == avg_n - 8'd1;
    wire seq_end = rec_end && (!is_avg || avg_last); // [R11]
    wire [11:0] gap_a = idx_ff + WAC_DIV_POINTS;
    wire [11:0] gap_addr = (gap_a >= rec_len) ? gap_a - rec_len : gap_a;

    // Register read selection; control state and status visible.
    wire [31:0] rd_mux = hit_ctrl ? {22'h0, trig_norm_ff, tb_ff, avg_sel_ff, mode_ff}
        : hit_stat ? {10'h0, avg_cnt_ff, idx_ff[11:4], scan, interp, eff_mode, st_ff}
        : hit_ar ? {26'h0, ar_h_ff, ar_v_ff, ar_sub_ff, 1'b0, ar_on_ff}
        : 32'h0;

    assign PREADY = 1'b1;
    assign PSLVERR = acc_en && !mapped;
    assign PRDATA = prdata_ff;
    assign PT_OUT = pt_ff;
    assign AR_OUT = ar_ff;
    assign AR_LED = ar_on_ff; // [R16]
    assign RATE_DIV = HIGH_BW ? 4'd1 : 4'd2; // [R2] relative to the 1 GS/s converter clock.

    // Read data registered on the setup phase so it is stable at access.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prdata_ff <= 32'h0;
        end else begin
            prdata_ff <= (PSEL && !PENABLE && !PWRITE) ? rd_mux : prdata_ff;
        end
    end

    // Configuration writes; autorange activation forces sample mode.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_ff <= WAC_MODE_SAMPLE; // [R8]
            avg_sel_ff <= 2'd0;
            tb_ff <= WAC_TB_RESET;
            trig_norm_ff <= 1'b0;
        end else if (ar_start) begin
            mode_ff <= WAC_MODE_SAMPLE; // [R19]
        end else if (ctrl_wr) begin
            mode_ff <= (wr_mode == 2'b11) ? mode_ff : wr_mode;
            avg_sel_ff <= PWDATA[WAC_CTRL_AVG_LSB +: 2]; // [R7]
            tb_ff <= wr_tb;
            trig_norm_ff <= PWDATA[WAC_CTRL_TRIGNORM_BIT];
        end
    end

    // Run, stop and single sequence control.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_ff <= WAC_ST_STOP;
            armed_ff <= 1'b0;
        end else begin
            if (ar_start) begin
                st_ff <= WAC_ST_RUN; // [R19]
            end else if (p_single) begin
                st_ff <= WAC_ST_SINGLE; // [R10]
            end else if (p_runstop) begin
                st_ff <= running ? WAC_ST_STOP : WAC_ST_RUN; // [R9]
            end else if (st_ff == WAC_ST_SINGLE && seq_end) begin
                st_ff <= WAC_ST_STOP; // [R10] [R11]
            end
            armed_ff <= p_single ? 1'b0 : (armed_ff || (st_ff == WAC_ST_SINGLE
                && SMP_IN.valid && SMP_IN.trig));
        end
    end

    // Autorange state: enable, sub-mode, per-axis tracking and actions.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ar_on_ff <= 1'b0; // [R16]
            ar_sub_ff <= WAC_AR_BOTH;
            ar_v_ff <= 1'b0;
            ar_h_ff <= 1'b0;
            ar_ff <= '0;
        end else begin
            ar_on_ff <= ar_next;
            if (ar_wr && PWDATA[3:2] != 2'b11) begin
                ar_sub_ff <= wac_arsub_t'(PWDATA[3:2]); // [R17]
            end
            if (ar_start) begin
                ar_v_ff <= ar_sub_ff != WAC_AR_HORZ;
                ar_h_ff <= ar_sub_ff != WAC_AR_VERT;
            end else begin
                ar_v_ff <= ar_next && ar_v_ff && !(evt_wr && PWDATA[WAC_EVT_VSCALE_BIT]); // [R21]
                ar_h_ff <= ar_next && ar_h_ff && !(evt_wr && PWDATA[WAC_EVT_HSCALE_BIT]); // [R21]
            end
            ar_ff.force_cfg <= ar_start; // [R19]
            ar_ff.restore <= p_undo; // [R17]
            ar_ff.vert_en <= ar_v_ff;
            ar_ff.horz_en <= ar_h_ff;
            // The sub-mode in force now decides which axis conditions count.
            ar_ff.readjust <= ar_on_ff && evt_wr && ((PWDATA[WAC_EVT_PERIOD_BIT] && ar_h_ff
                && ar_sub_ff != WAC_AR_VERT)
                || (PWDATA[WAC_EVT_AMPL_BIT] && ar_v_ff && ar_sub_ff != WAC_AR_HORZ)
                || PWDATA[WAC_EVT_TLEVEL_BIT]); // [R18]
        end
    end

    // Interval extremes, interpolation phase and record position.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            idx_ff <= 12'd0;
            in_int_ff <= 1'b0;
            max_ff <= 8'h00;
            min_ff <= 8'hFF;
            last_ff <= 8'h00;
            interp_ff <= 2'd0;
            avg_cnt_ff <= 8'd0;
            acc_done_ff <= 8'd0;
        end else if (cfg_chg || p_single || ar_start) begin
            idx_ff <= 12'd0; // [R23]
            in_int_ff <= 1'b0;
            acc_done_ff <= 8'd0;
            avg_cnt_ff <= 8'd0;
            interp_ff <= 2'd0;
        end else if (step) begin
            max_ff <= nmax;
            min_ff <= nmin;
            last_ff <= cur;
            interp_ff <= interp ? 2'(interp_ff + 2'd1) : 2'd0; // [R3]
            in_int_ff <= is_peak && !in_int_ff; // [R4]
            if (pt_done) begin
                idx_ff <= rec_end ? 12'd0 : idx_ff + 12'd1; // [R13]
            end
            if (rec_end && is_avg) begin
                acc_done_ff <= avg_last ? 8'd0 : acc_done_ff + 8'd1;
                avg_cnt_ff <= acc_done_ff + 8'd1;
            end
        end
    end

    // Average accumulator memory, one word per record point.
    always_ff @(posedge CLK) begin
        if (pt_done && is_avg) begin
            acc_mem[idx_ff] <= acc_sum; // [R22]
        end
    end

    // Point output to the record store; nothing is written while stopped.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pt_ff <= '0;
        end else begin
            pt_ff.we <= pt_done && (!is_avg || avg_last); // [R15]
            pt_ff.addr <= idx_ff; // [R1]
            pt_ff.max <= is_avg ? avg_val : nmax;
            pt_ff.min <= is_avg ? avg_val : nmin;
            pt_ff.blank <= 1'b0;
            if (scan && pt_done) begin
                pt_ff.blank <= 1'b1; // [R13] blank point 250 points ahead: one division in sample mode, two in peak detect.
                pt_ff.addr <= gap_addr;
            end
        end
    end

endmodule

// *** wac_chk.sv ***
// Port checker for the acquisition controller.
// Assumes it is bound to wac_ctrl, which has one clock domain.
`timescale 1ns/10ps
module wac_chk (
    input wire logic CLK, // Clock.
    input wire logic RESET_N, // Reset, low.
    input wire logic PSEL, // Select.
    input wire logic PENABLE, // Access.
    input wire logic [7:0] PADDR, // Address.
    input wire logic PREADY, // Ready.
    input wire logic PSLVERR, // Error.
    input wire logic HIGH_BW, // Strap.
    input wire wac_pkg::wac_pt_t PT_OUT, // Point.
    input wire logic AR_LED, // Lamp.
    input wire wac_pkg::wac_ar_t AR_OUT, // Actions.
    input wire logic [3:0] RATE_DIV // Divider.
);
    import wac_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // An access phase beyond the register map.
    sequence s_bad_acc;
        PSEL && PENABLE && (PADDR > WAC_EVT_OFS);
    endsequence
    // The autorange lamp coming on.
    sequence s_ar_on;
        $rose(AR_LED);
    endsequence
    a_ready_always: assert property (PREADY)
        else $error("ready low");
    a_bad_addr_err: assert property (s_bad_acc |-> PSLVERR)
        else $error("no error on unmapped access");
    a_rate_limit: assert property (RATE_DIV == (HIGH_BW ? 4'h1 : 4'h2))
        else $error("rate divider wrong");
    a_lamp_off_reset: assert property ($rose(RESET_N) |-> !AR_LED)
        else $error("lamp on after reset");
    a_point_in_rec: assert property (PT_OUT.we |-> PT_OUT.addr < WAC_SAMPLE_POINTS)
        else $error("point address out of record");
    a_peak_order: assert property (PT_OUT.we |-> PT_OUT.max >= PT_OUT.min)
        else $error("max below min");
    a_force_on_entry: assert property (s_ar_on |-> $past(AR_OUT.force_cfg) or ##[0:1] AR_OUT.force_cfg)
        else $error("no forced setup on entry");
    a_adjust_active: assert property (AR_OUT.readjust |-> AR_LED || $past(AR_LED))
        else $error("readjust while inactive");
    a_undo_pulse: assert property (AR_OUT.restore |=> !AR_OUT.restore)
        else $error("restore not a pulse");
endmodule

// *** wac_src.sv ***
// Digitizer model: one sample a clock while enabled, trigger on each.
// Assumes the bench enables it during each single sequence and for 30 clocks past its end.
`timescale 1ns/10ps
module wac_src (
    input wire logic CLK, // Clock.
    input wire logic RESET_N, // Reset, low.
    input wire logic en, // Stream on.
    input wire logic spike, // Send one glitch.
    input wire logic [7:0] lvl, // Steady level.
    output wac_pkg::wac_smp_t smp // Sample.
);
    import wac_pkg::*;
    // Idle data flips every cycle so a stale value is never mistaken for one.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            smp <= '0;
        end else begin
            smp.valid <= en;
            smp.trig <= en;
            smp.data <= !en ? ~smp.data : (spike ? 8'hF0 : lvl);
        end
    end
endmodule

// *** tb_top.sv ***
// Bench for the acquisition controller: APB master, sample source, scenarios.
// Assumes wac_pkg, wac_src and wac_chk are compiled before it.
`timescale 1ns/10ps
module tb_top;
    import wac_pkg::*;
    logic clk, reset_n, psel, penable, pwrite, pslverr, pready, ar_led, high_bw;
    logic en, spike, last_err;
    logic [7:0] paddr, lvl;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] rate_div;
    logic [15:0] odd_val;
    logic [11:0] last_addr;
    wac_smp_t smp;
    wac_pt_t pt;
    wac_ar_t ar_o;
    int fail_count, checks_done, cyc, pts, odd, flat, n_adj, n_frc, n_rst;

    wac_ctrl uut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .HIGH_BW(high_bw), .SMP_IN(smp),
        .PT_OUT(pt), .AR_LED(ar_led), .AR_OUT(ar_o), .RATE_DIV(rate_div));
    wac_src src (.CLK(clk), .RESET_N(reset_n), .en(en), .spike(spike), .lvl(lvl),
        .smp(smp));

    // Clock with a 50 ns period.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Tallies record points and autorange pulses, and cuts a hang short.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (pt.we === 1'b1) begin
            pts <= pts + 1;
            last_addr <= pt.addr;
            if (pt.max !== pt.min) begin
                odd <= odd + 1;
                odd_val <= {pt.max, pt.min};
            end
            if (pt.max === lvl && pt.min === lvl) flat <= flat + 1;
        end
        if (ar_o.readjust === 1'b1) n_adj <= n_adj + 1;
        if (ar_o.force_cfg === 1'b1) n_frc <= n_frc + 1;
        if (ar_o.restore === 1'b1) n_rst <= n_rst + 1;
        if (cyc == 40000) begin
            fail_count++;
            give_verdict();
        end
    end

    // Compares one value and counts it.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Builds a control word.
    function automatic logic [31:0] ctl(logic [1:0] m, logic [1:0] a, logic [4:0] t, logic n);
        return {22'h0, n, t, a, m};
    endfunction

    // Reset state and an unmapped read.
    task automatic t_reset();
        apb(WAC_STAT_OFS, 1'b0, 32'h0);
        chk(rd[3:0], 4'h0);
        apb(WAC_AR_OFS, 1'b0, 32'h0);
        chk(rd[0], 1'b0);
        apb(8'h40, 1'b0, 32'h0);
        chk(last_err, 1'b1);
    endtask

    // Timebase boundaries against interpolation, fallback and scan.
    task automatic t_modes();
        logic [4:0] tbc [6] = '{5'h05, 5'h06, 5'h10, 5'h11, 5'h15, 5'h15};
        logic [3:0] ex [6] = '{4'h4, 4'h0, 4'h0, 4'h1, 4'h9, 4'h1};
        for (int i = 0; i < 6; i++) begin
            apb(WAC_CTRL_OFS, 1'b1, ctl(2'h1, 2'h0, tbc[i], i == 5));
            apb(WAC_STAT_OFS, 1'b0, 32'h0);
            chk(rd[5:2], ex[i]);
        end
        apb(WAC_CTRL_OFS, 1'b0, 32'h0);
        chk(rd, ctl(2'h1, 2'h0, 5'h15, 1'b1));
    endtask

    // Run/stop presses toggle the state.
    task automatic t_runstop();
        for (int i = 1; i >= 0; i--) begin
            apb(WAC_CMD_OFS, 1'b1, 32'h1);
            apb(WAC_STAT_OFS, 1'b0, 32'h0);
            chk(rd[1:0], i);
        end
    endtask

    // One single sequence with the source streaming past its end.
    task automatic t_single(input logic [31:0] cv, input int npts, input logic sp);
        apb(WAC_CTRL_OFS, 1'b1, cv);
        pts = 0;
        odd = 0;
        flat = 0;
        apb(WAC_CMD_OFS, 1'b1, 32'h2);
        en <= 1'b1;
        repeat (100) @(posedge clk);
        spike <= sp;
        @(posedge clk);
        spike <= 1'b0;
        while (pts < npts) @(posedge clk);
        repeat (30) @(posedge clk);
        en <= 1'b0;
        repeat (4) @(posedge clk);
        chk(pts, npts);
        chk(last_addr, npts - 1);
        chk(odd, sp);
        if (sp) chk(odd_val, {8'hF0, lvl});
        else chk(flat, npts);
        apb(WAC_STAT_OFS, 1'b0, 32'h0);
        chk(rd[1:0], 2'h0);
    endtask

    // Autorange entry, toggling, deactivation, readjust, axis cancel, undo.
    task automatic t_autorange();
        int a0;
        apb(WAC_CTRL_OFS, 1'b1, ctl(2'h1, 2'h0, 5'h11, 1'b1));
        apb(WAC_CMD_OFS, 1'b1, 32'h4);
        apb(WAC_STAT_OFS, 1'b0, 32'h0);
        chk(rd[3:0], 4'h1);
        chk(n_frc, 1);
        chk(ar_led, 1'b1);
        for (int b = 2; b <= 8; b++) begin
            if (b == 2) apb(WAC_CMD_OFS, 1'b1, 32'h4);
            else if (b == 8) apb(WAC_CMD_OFS, 1'b1, 32'h2);
            else apb(WAC_EVT_OFS, 1'b1, 32'h1 << b);
            apb(WAC_AR_OFS, 1'b0, 32'h0);
            chk(rd[0], 1'b0);
            chk(ar_led, 1'b0);
            apb(WAC_CMD_OFS, 1'b1, 32'h4);
            apb(WAC_AR_OFS, 1'b0, 32'h0);
            chk(rd[0], 1'b1);
        end
        a0 = n_adj;
        apb(WAC_EVT_OFS, 1'b1, 32'h1);
        apb(WAC_AR_OFS, 1'b1, 32'h34);
        apb(WAC_EVT_OFS, 1'b1, 32'h1);
        apb(WAC_EVT_OFS, 1'b1, 32'h2);
        apb(WAC_AR_OFS, 1'b1, 32'h30);
        chk(n_adj - a0, 2);
        apb(WAC_EVT_OFS, 1'b1, 32'h4);
        apb(WAC_STAT_OFS, 1'b0, 32'h0);
        chk(n_adj - a0, 3);
        apb(WAC_EVT_OFS, 1'b1, 32'h100);
        apb(WAC_AR_OFS, 1'b0, 32'h0);
        chk(rd[5:4], 2'h2);
        chk({ar_o.vert_en, ar_o.horz_en}, 2'h1);
        apb(WAC_EVT_OFS, 1'b1, 32'h200);
        apb(WAC_AR_OFS, 1'b0, 32'h0);
        chk(rd[5:4], 2'h0);
        apb(WAC_CMD_OFS, 1'b1, 32'h8);
        apb(WAC_STAT_OFS, 1'b0, 32'h0);
        chk(n_rst, 1);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        reset_n = 1'b0;
        {psel, penable, pwrite, en, spike} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        lvl = 8'h40;
        high_bw = 1'b1;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_modes();
        t_runstop();
        t_single(ctl(2'h0, 2'h0, 5'h0A, 1'b1), 2500, 1'b0);
        t_single(ctl(2'h1, 2'h0, 5'h11, 1'b1), 1250, 1'b1);
        t_single(ctl(2'h2, 2'h0, 5'h0A, 1'b1), 2500, 1'b0);
        t_autorange();
        high_bw <= 1'b0;
        repeat (2) @(posedge clk);
        chk(rate_div, 4'h2);
        give_verdict();
    end
endmodule

bind wac_ctrl wac_chk chk_i (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .HIGH_BW(HIGH_BW), .PT_OUT(PT_OUT), .AR_LED(AR_LED), .AR_OUT(AR_OUT),
    .RATE_DIV(RATE_DIV));
